// >>> design/csamr_consts.svh
// Purpose: Constants for the calibration, status and alarm mask register bank.
// Assumes: Register indexes are word indexes; the byte address is four times the index.
// Notes: Field positions live in the packed structs of csamr_pkg.
`ifndef CSAMR_CONSTS_SVH
`define CSAMR_CONSTS_SVH

`define CSAMR_IDX_CAL_ENABLE 6'h08
`define CSAMR_IDX_USER_GAIN 6'h09
`define CSAMR_IDX_USER_OFFSET 6'h0a
`define CSAMR_IDX_STATUS 6'h0b
`define CSAMR_IDX_ALARM_MASK 6'h0c

`define CSAMR_RST_ZERO 16'h0000
`define CSAMR_RST_STATUS 16'h1000

// Bits that are sticky, cleared by writing one, and able to raise the alarm.
`define CSAMR_STICKY_BITS 16'h083f
// Mask bits that software can hold; the others read as zero.
`define CSAMR_MASK_BITS 16'h083f

`define CSAMR_GAIN_UNITY 17'h10000
`define CSAMR_SYNC_STAGES 2

`endif

// >>> design/csamr_pkg.sv
// Purpose: Types shared by the register bank modules.
// Assumes: All registers are 16 bits wide.
// Notes: Field order follows the bit layout from bit 15 down to bit 0.
package csamr_pkg;

  typedef struct packed {
    logic [2:0] reserved;
    logic load_learn_done;
    logic watchdog_fault_flag;
    logic converter_d_power_good;
    logic converter_c_power_good;
    logic converter_b_power_good;
    logic converter_a_power_good;
    logic toggle_readback;
    logic frame_check_error;
    logic overheat_flag;
    logic channel_d_fault;
    logic channel_c_fault;
    logic channel_b_fault;
    logic channel_a_fault;
  } csamr_status_type;

  typedef struct packed {
    logic [3:0] reserved_high;
    logic mask_watchdog_alarm;
    logic [4:0] reserved_mid;
    logic mask_frame_check_alarm;
    logic mask_overheat_alarm;
    logic mask_channel_d_alarm;
    logic mask_channel_c_alarm;
    logic mask_channel_b_alarm;
    logic mask_channel_a_alarm;
  } csamr_mask_type;

endpackage

// >>> design/csamr_sync.sv
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Each bit is a slow level; no bus coherence across bits is implied.
// Notes: The first stage feeds only the second stage.
module csamr_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("csamr_sync needs at least one bit");
  end

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> design/csamr_regs.sv
// Purpose: Calibration, status and alarm mask registers of a four-channel converter, Avalon-MM slave.
// Assumes: 32-bit Avalon-MM with byte addresses; 16-bit registers sit in the low half of a word.
// Notes: Gain is a signed fraction around unity, offset a signed code; both pass only while enabled.
//
// Overview of operation
// - Calibration enable bit zero turns on gain and offset correction; resets off.
// - User gain register holds sixteen read-write bits, resets to zero.
// - User offset register holds sixteen read-write bits, resets to zero.
// - Status bit twelve shows load learning finished; status resets to 0x1000.
// - Status bit eleven is set on a watchdog fault; resets to zero.
// - Status bits ten to seven show converter D to A power good.
// - Status bit six mirrors the host toggle bit for readback.
// - Status bit five is set on a received frame check error.
// - Status bit four is set on an overheat condition.
// - Status bits three to zero flag faults on channels D to A.
// - Mask bit eleven keeps a watchdog fault off the alarm pin.
// - Mask bit five keeps a frame check error off the alarm pin.
// - Mask bit four keeps overheat off the alarm pin.
// - Mask bits three to zero keep channel faults off the alarm pin.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "csamr_consts.svh"

module csamr_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  input wire logic LEARN_START,
  input wire logic LEARN_FINISH,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic FRAME_CRC_BAD,
  input wire logic HOST_TOGGLE_BIT,
  input wire logic [3:0] POWER_GOOD_PINS,
  input wire logic OVERHEAT_PIN,
  input wire logic [3:0] CHANNEL_FAULT_PINS,
  input wire logic [15:0] DAC_CODE_IN,
  input wire logic DAC_CODE_VALID,
  output logic CALIBRATION_ON,
  output logic [15:0] USER_GAIN_VALUE,
  output logic [15:0] USER_OFFSET_VALUE,
  output logic [15:0] CORRECTED_CODE,
  output logic CORRECTED_VALID,
  output logic ALARM
);

  if (DATA_W != 32) begin : g_bad_data
    $error("csamr_regs supports only 32-bit data");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("csamr_regs needs at least 8 address bits");
  end

  csamr_pkg::csamr_status_type status;
  csamr_pkg::csamr_mask_type mask;
  csamr_pkg::csamr_status_type set_flags;
  csamr_pkg::csamr_status_type next_status;
  logic [8:0] pin_sync;
  logic [3:0] pg_sync;
  logic overheat_sync;
  logic [3:0] fault_sync;
  logic [5:0] index;
  logic aligned;
  logic [15:0] lane_mask;
  logic wr_take;
  logic [15:0] wdata16;
  logic [15:0] clr_word;
  logic [15:0] rd_word;
  logic [15:0] src_bits;

  // Power good, overheat and channel fault arrive from analog comparators off the clock domain.
  csamr_sync #(
    .WIDTH(9)
  ) u_pin_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .async_in({POWER_GOOD_PINS, OVERHEAT_PIN, CHANNEL_FAULT_PINS}),
    .sync_out(pin_sync)
  );

  assign pg_sync = pin_sync[8:5];
  assign overheat_sync = pin_sync[4];
  assign fault_sync = pin_sync[3:0];

  // Bus decode. A register answers only at a word-aligned address; anything else reads zero.
  assign index = ADDRESS[7:2];
  assign aligned = (ADDRESS[1:0] == 2'h0) && ((ADDRESS >> 8) == '0);
  assign lane_mask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
  assign wdata16 = WRITEDATA[15:0];
  // A write counts only at the edge where the master sees waitrequest low.
  assign wr_take = WRITE && !WAITREQUEST && aligned;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WAITREQUEST <= 1'b1;
    end else if (WAITREQUEST && (READ || WRITE)) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    if (aligned) begin
      case (index)
        `CSAMR_IDX_CAL_ENABLE: rd_word = {15'h0, CALIBRATION_ON};
        `CSAMR_IDX_USER_GAIN: rd_word = USER_GAIN_VALUE;
        `CSAMR_IDX_USER_OFFSET: rd_word = USER_OFFSET_VALUE;
        `CSAMR_IDX_STATUS: rd_word = status;
        `CSAMR_IDX_ALARM_MASK: rd_word = mask;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Read data is loaded with the acknowledge so it stands at the sampling edge.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      READDATA <= '0;
    end else if (WAITREQUEST && READ) begin
      READDATA <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CALIBRATION_ON <= 1'b0;
    end else if (wr_take && index == `CSAMR_IDX_CAL_ENABLE && BYTEENABLE[0]) begin
      CALIBRATION_ON <= wdata16[0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      USER_GAIN_VALUE <= `CSAMR_RST_ZERO;
    end else if (wr_take && index == `CSAMR_IDX_USER_GAIN) begin
      USER_GAIN_VALUE <= (USER_GAIN_VALUE & ~lane_mask) | (wdata16 & lane_mask);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      USER_OFFSET_VALUE <= `CSAMR_RST_ZERO;
    end else if (wr_take && index == `CSAMR_IDX_USER_OFFSET) begin
      USER_OFFSET_VALUE <= (USER_OFFSET_VALUE & ~lane_mask) | (wdata16 & lane_mask);
    end
  end

  // Only the defined mask bits are stored, so reserved positions cannot steer the alarm.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mask <= `CSAMR_RST_ZERO;
    end else if (wr_take && index == `CSAMR_IDX_ALARM_MASK) begin
      mask <= ((mask & ~lane_mask) | (wdata16 & lane_mask)) & `CSAMR_MASK_BITS;
    end
  end

  // Fault flags are sticky and cleared by writing one; a set in the same cycle beats the clear.
  assign clr_word = (wr_take && index == `CSAMR_IDX_STATUS) ? (wdata16 & lane_mask & `CSAMR_STICKY_BITS) : 16'h0000;

  always_comb begin
    set_flags = `CSAMR_RST_ZERO;
    set_flags.watchdog_fault_flag = WATCHDOG_EXPIRED;
    set_flags.frame_check_error = FRAME_CRC_BAD;
    set_flags.overheat_flag = overheat_sync;
    set_flags.channel_d_fault = fault_sync[3];
    set_flags.channel_c_fault = fault_sync[2];
    set_flags.channel_b_fault = fault_sync[1];
    set_flags.channel_a_fault = fault_sync[0];
    next_status = ((status & ~clr_word) | set_flags) & `CSAMR_STICKY_BITS;
    // Finish wins over a start that lands in the same cycle.
    next_status.load_learn_done = LEARN_FINISH || (status.load_learn_done && !LEARN_START);
    next_status.converter_d_power_good = pg_sync[3];
    next_status.converter_c_power_good = pg_sync[2];
    next_status.converter_b_power_good = pg_sync[1];
    next_status.converter_a_power_good = pg_sync[0];
    next_status.toggle_readback = HOST_TOGGLE_BIT;
    next_status.reserved = 3'h0;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status <= `CSAMR_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // Power good, learn and toggle bits are outside the sticky set and never reach the alarm.
  assign src_bits = status & `CSAMR_STICKY_BITS;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ALARM <= 1'b0;
    end else begin
      ALARM <= |(src_bits & ~mask);
    end
  end

  // Correction: code times (1 + gain/65536) plus offset, saturated to the code range.
  // The gain factor is kept modulo 2^17, which holds it exactly within 0.5 to 1.5.
  logic [16:0] gain_factor;
  logic [32:0] product;
  logic [18:0] corr_sum;
  logic [15:0] next_code;

  assign gain_factor = `CSAMR_GAIN_UNITY + {USER_GAIN_VALUE[15], USER_GAIN_VALUE};
  assign product = {17'h0, DAC_CODE_IN} * {16'h0000, gain_factor};
  assign corr_sum = {2'b00, product[32:16]} + {{3{USER_OFFSET_VALUE[15]}}, USER_OFFSET_VALUE};

  always_comb begin
    if (!CALIBRATION_ON) begin
      next_code = DAC_CODE_IN;
    end else if (corr_sum[18]) begin
      next_code = 16'h0000;
    end else if (corr_sum[17:16] != 2'h0) begin
      next_code = 16'hffff;
    end else begin
      next_code = corr_sum[15:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CORRECTED_CODE <= 16'h0000;
      CORRECTED_VALID <= 1'b0;
    end else begin
      CORRECTED_VALID <= DAC_CODE_VALID;
      if (DAC_CODE_VALID) begin
        CORRECTED_CODE <= next_code;
      end
    end
  end

  AST_CAL_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_take && index == `CSAMR_IDX_CAL_ENABLE && BYTEENABLE[0]) |=> (CALIBRATION_ON == $past(WRITEDATA[0])))
    else $error("calibration enable did not take the written bit");

  AST_CAL_OFF_PASS: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DAC_CODE_VALID && !CALIBRATION_ON) |=> (CORRECTED_VALID && CORRECTED_CODE == $past(DAC_CODE_IN)))
    else $error("code changed while correction was off");

  AST_GAIN_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_take && index == `CSAMR_IDX_USER_GAIN && BYTEENABLE[1:0] == 2'h3)
    |=> (USER_GAIN_VALUE == $past(WRITEDATA[15:0])))
    else $error("gain register did not take the written value");

  AST_OFFSET_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_take && index == `CSAMR_IDX_USER_OFFSET && BYTEENABLE[1:0] == 2'h3)
    |=> (USER_OFFSET_VALUE == $past(WRITEDATA[15:0])))
    else $error("offset register did not take the written value");

  AST_LEARN_DONE: assert property (@(posedge SYS_CLK) disable iff (RST)
    LEARN_FINISH |=> status.load_learn_done)
    else $error("learn done not set after finish");

  AST_LEARN_START: assert property (@(posedge SYS_CLK) disable iff (RST)
    (LEARN_START && !LEARN_FINISH) |=> !status.load_learn_done)
    else $error("learn done not cleared by start");

  AST_WATCHDOG_SET_WINS: assert property (@(posedge SYS_CLK) disable iff (RST)
    WATCHDOG_EXPIRED |=> status.watchdog_fault_flag)
    else $error("watchdog flag lost");

  AST_PG_FOLLOW: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##3 ({status.converter_d_power_good, status.converter_c_power_good,
          status.converter_b_power_good, status.converter_a_power_good} == $past(POWER_GOOD_PINS, 3)))
    else $error("power good bits do not follow the pins");

  AST_TOGGLE_COPY: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (status.toggle_readback == $past(HOST_TOGGLE_BIT)))
    else $error("toggle readback differs from the host toggle bit");

  AST_CRC_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    FRAME_CRC_BAD |=> status.frame_check_error)
    else $error("frame check flag lost");

  AST_HEAT_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##3 (!$past(OVERHEAT_PIN, 3) || status.overheat_flag))
    else $error("overheat flag not set three cycles after the pin");

  AST_FAULT_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##3 (({status.channel_d_fault, status.channel_c_fault, status.channel_b_fault, status.channel_a_fault}
          & $past(CHANNEL_FAULT_PINS, 3)) == $past(CHANNEL_FAULT_PINS, 3)))
    else $error("channel fault flag not set from its pin");

  AST_MASK_WATCHDOG: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mask.mask_watchdog_alarm && src_bits == 16'h0800) |=> !ALARM)
    else $error("masked watchdog fault raised the alarm");

  AST_MASK_CRC: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mask.mask_frame_check_alarm && src_bits == 16'h0020) |=> !ALARM)
    else $error("masked frame check error raised the alarm");

  AST_MASK_HEAT: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mask.mask_overheat_alarm && src_bits == 16'h0010) |=> !ALARM)
    else $error("masked overheat raised the alarm");

  AST_MASK_FAULT: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mask[3:0] == 4'hf && src_bits[11:4] == 8'h00) |=> !ALARM)
    else $error("masked channel faults raised the alarm");

  AST_ALARM_TRACK: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (ALARM == $past(|(src_bits & ~mask))))
    else $error("alarm pin does not match unmasked flags");

  AST_RSVD_ZERO: assert property (@(posedge SYS_CLK) disable iff (RST)
    (READ && !WAITREQUEST && aligned && index == `CSAMR_IDX_CAL_ENABLE) |-> (READDATA[31:1] == '0))
    else $error("reserved calibration bits read nonzero");

  AST_ONE_WAIT: assert property (@(posedge SYS_CLK) disable iff (RST)
    ((READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer not one cycle wide");

  COV_ALARM_RISE: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(ALARM));
  COV_STATUS_CLEAR: cover property (@(posedge SYS_CLK) disable iff (RST) (clr_word != 16'h0000));
  COV_CAL_ACTIVE: cover property (@(posedge SYS_CLK) disable iff (RST) (CALIBRATION_ON && DAC_CODE_VALID));
  COV_SET_CLEAR_RACE: cover property (@(posedge SYS_CLK) disable iff (RST) (clr_word[11] && WATCHDOG_EXPIRED));

endmodule

// >>> bench/csamr_regs_test.sv
// Purpose: Self-checking bench for the calibration, status and alarm mask register bank.
// Assumes: Avalon-MM with one wait state, byte address four times the register index.
// Notes: Pin inputs pass a two-stage synchroniser, so waits of five cycles leave margin.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module csamr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic learn_start = 1'b0;
  logic learn_finish = 1'b0;
  logic watchdog_expired = 1'b0;
  logic frame_crc_bad = 1'b0;
  logic host_toggle_bit = 1'b0;
  logic [3:0] power_good_pins = 4'h0;
  logic overheat_pin = 1'b0;
  logic [3:0] channel_fault_pins = 4'h0;
  logic [15:0] dac_code_in = 16'h0000;
  logic dac_code_valid = 1'b0;
  logic calibration_on;
  logic [15:0] user_gain_value;
  logic [15:0] user_offset_value;
  logic [15:0] corrected_code;
  logic corrected_valid;
  logic alarm;
  int n_errors = 0;
  int n_checks = 0;

  csamr_regs dut_u (
    .SYS_CLK(sys_clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata), .WAITREQUEST(waitrequest),
    .LEARN_START(learn_start), .LEARN_FINISH(learn_finish), .WATCHDOG_EXPIRED(watchdog_expired),
    .FRAME_CRC_BAD(frame_crc_bad), .HOST_TOGGLE_BIT(host_toggle_bit), .POWER_GOOD_PINS(power_good_pins),
    .OVERHEAT_PIN(overheat_pin), .CHANNEL_FAULT_PINS(channel_fault_pins), .DAC_CODE_IN(dac_code_in),
    .DAC_CODE_VALID(dac_code_valid), .CALIBRATION_ON(calibration_on), .USER_GAIN_VALUE(user_gain_value),
    .USER_OFFSET_VALUE(user_offset_value), .CORRECTED_CODE(corrected_code),
    .CORRECTED_VALID(corrected_valid), .ALARM(alarm)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("Counts: checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // The request is raised one edge after entry, so back-to-back calls never drive a strobe twice at one edge.
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                          output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    // Only the watchdog process ends a wait that never gets its answer.
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h00000000, 4'hf, q);
    `CHK(q, e)
  endtask

  task automatic end_test(input string name);
    $display("Test %s ended, errors so far %0d", name, n_errors);
  endtask

  task automatic test_reset();
    rd_chk(8'h20, 32'h00000000);
    rd_chk(8'h24, 32'h00000000);
    rd_chk(8'h28, 32'h00000000);
    rd_chk(8'h2c, 32'h00001000);
    rd_chk(8'h30, 32'h00000000);
    rd_chk(8'h34, 32'h00000000);
    `CHK(calibration_on, 1'b0)
    `CHK(alarm, 1'b0)
    end_test("reset");
  endtask

  task automatic test_rw();
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h00000001);
    `CHK(calibration_on, 1'b1)
    wr(8'h24, 32'h0000a5c3);
    rd_chk(8'h24, 32'h0000a5c3);
    wr(8'h24, 32'h0000ffff, 4'h1);
    rd_chk(8'h24, 32'h0000a5ff);
    `CHK(user_gain_value, 16'ha5ff)
    wr(8'h28, 32'h00005a3c);
    rd_chk(8'h28, 32'h00005a3c);
    `CHK(user_offset_value, 16'h5a3c)
    wr(8'h30, 32'hffffffff);
    rd_chk(8'h30, 32'h0000083f);
    wr(8'h30, 32'h00000000);
    wr(8'h34, 32'hffffffff);
    rd_chk(8'h34, 32'h00000000);
    wr(8'h20, 32'h00000000);
    rd_chk(8'h20, 32'h00000000);
    `CHK(calibration_on, 1'b0)
    wr(8'h24, 32'h00000000);
    wr(8'h28, 32'h00000000);
    end_test("rw");
  endtask

  task automatic test_hw();
    @(posedge sys_clk);
    power_good_pins <= 4'b0101;
    host_toggle_bit <= 1'b1;
    cyc(5);
    wr(8'h2c, 32'h0000ffff);
    rd_chk(8'h2c, 32'h000012c0);
    `CHK(alarm, 1'b0)
    @(posedge sys_clk);
    learn_start <= 1'b1;
    @(posedge sys_clk);
    learn_start <= 1'b0;
    rd_chk(8'h2c, 32'h000002c0);
    @(posedge sys_clk);
    learn_finish <= 1'b1;
    @(posedge sys_clk);
    learn_finish <= 1'b0;
    rd_chk(8'h2c, 32'h000012c0);
    @(posedge sys_clk);
    power_good_pins <= 4'b1010;
    host_toggle_bit <= 1'b0;
    cyc(5);
    rd_chk(8'h2c, 32'h00001500);
    @(posedge sys_clk);
    power_good_pins <= 4'h0;
    cyc(5);
    end_test("hw");
  endtask

  task automatic set_src(input int i, input logic v);
    case (i)
      0: watchdog_expired <= v;
      1: frame_crc_bad <= v;
      2: overheat_pin <= v;
      default: channel_fault_pins[6-i] <= v;
    endcase
  endtask

  // Sources are watchdog, frame check, overheat, then channels D to A.
  task automatic test_sticky();
    int bp;
    for (int i = 0; i < 7; i++) begin
      bp = (i == 0) ? 11 : 6 - i;
      @(posedge sys_clk);
      set_src(i, 1'b1);
      cyc(5);
      set_src(i, 1'b0);
      cyc(5);
      rd_chk(8'h2c, 32'h00001000 | (32'h1 << bp));
      wr(8'h30, 32'h0000083f & ~(32'h1 << bp));
      cyc(2);
      `CHK(alarm, 1'b1)
      wr(8'h30, 32'h0000083f);
      cyc(2);
      `CHK(alarm, 1'b0)
      wr(8'h2c, 32'h1 << bp);
      rd_chk(8'h2c, 32'h00001000);
      wr(8'h30, 32'h00000000);
      cyc(2);
      `CHK(alarm, 1'b0)
    end
    // A clear that meets a still active watchdog source must lose to the set.
    @(posedge sys_clk);
    watchdog_expired <= 1'b1;
    wr(8'h2c, 32'h00000800);
    rd_chk(8'h2c, 32'h00001800);
    watchdog_expired <= 1'b0;
    wr(8'h2c, 32'h00000800);
    rd_chk(8'h2c, 32'h00001000);
    end_test("sticky");
  endtask

  task automatic corr_chk(input logic [15:0] x, input logic [15:0] e);
    @(posedge sys_clk);
    dac_code_in <= x;
    dac_code_valid <= 1'b1;
    @(posedge sys_clk);
    dac_code_valid <= 1'b0;
    @(posedge sys_clk);
    `CHK(corrected_valid, 1'b1)
    `CHK(corrected_code, e)
  endtask

  // Gain 0x8000 is minus one half around unity, so the code is halved before the offset.
  task automatic test_corr();
    wr(8'h24, 32'h00008000);
    wr(8'h28, 32'h00000010);
    corr_chk(16'h1000, 16'h1000);
    wr(8'h20, 32'h00000001);
    corr_chk(16'h1000, 16'h0810);
    wr(8'h24, 32'h00000000);
    wr(8'h28, 32'h00007fff);
    corr_chk(16'hfff0, 16'hffff);
    wr(8'h28, 32'h00008000);
    corr_chk(16'h0100, 16'h0000);
    wr(8'h20, 32'h00000000);
    end_test("corr");
  endtask

  initial begin
    cyc(3);
    rst <= 1'b0;
    test_reset();
    test_rw();
    test_hw();
    test_sticky();
    test_corr();
    final_report();
  end

  // The tests need about four hundred cycles, so this limit only trips on a hang.
  initial begin
    cyc(20000);
    n_errors++;
    final_report();
  end
endmodule
